// file: src/region_hold_pkg.sv
// Shared constants of the region freeze controller: register map, fields, reset values
`default_nettype none

package region_hold_pkg;

  // ----------------------------------------------------------------
  // Register port geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 2;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Word addresses of the registers
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_LOG     = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_VERSION = 2'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_W          = 3;
  localparam int CTRL_HALT_BIT   = 0;
  localparam int CTRL_CLEAR_BIT  = 1;
  localparam int CTRL_RESUME_BIT = 2;
  localparam int STAT_HALT_BIT   = 0;
  localparam int STAT_RESUME_BIT = 1;

  // ----------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
  // Layout version code; the value is arbitrary
  localparam logic [DATA_W-1:0] LAYOUT_VERSION = 32'h5A5A_0001;

  // ----------------------------------------------------------------
  // Handshake states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_STOPPING,
    SEQ_FROZEN,
    SEQ_STARTING
  } seq_state_t;

endpackage

`default_nettype wire

// file: src/freeze_sequencer.sv
// Stop/start handshake with the region logic and the freeze level it produces
`timescale 1ns/10ps
`default_nettype none

module freeze_sequencer (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic srst,
  input  wire logic halt_req,
  input  wire logic resume_req,
  input  wire logic quiesce_grant,
  input  wire logic launch_grant,
  output logic      quiesce_ask,
  output logic      launch_ask,
  output logic      hold,
  output logic      halt_done,
  output logic      resume_done
);
  import region_hold_pkg::*;

  typedef struct packed {
    seq_state_t state;
    logic       quiesce;
    logic       launch;
    logic       hold;
    logic       halt_done;
    logic       resume_done;
  } seq_t;

  seq_t seq_reg;
  seq_t seq_next;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    seq_next = seq_reg;
    if (!halt_req) seq_next.halt_done = 1'b0;
    if (!resume_req) seq_next.resume_done = 1'b0;
    unique case (seq_reg.state)
      SEQ_IDLE: begin
        if (halt_req) begin
          seq_next.state   = SEQ_STOPPING;
          seq_next.quiesce = 1'b1;
        end
      end
      SEQ_STOPPING: begin
        if (!halt_req) begin
          seq_next.state   = SEQ_IDLE;
          seq_next.quiesce = 1'b0;
        end else if (quiesce_grant) begin
          seq_next.state     = SEQ_FROZEN;
          seq_next.quiesce   = 1'b0;
          seq_next.hold      = 1'b1;
          seq_next.halt_done = 1'b1;
        end
      end
      SEQ_FROZEN: begin
        if (resume_req) begin
          seq_next.state  = SEQ_STARTING;
          seq_next.hold   = 1'b0;
          seq_next.launch = 1'b1;
        end
      end
      SEQ_STARTING: begin
        if (!resume_req) begin
          // abandoned resume refreezes, the region never launched
          seq_next.state  = SEQ_FROZEN;
          seq_next.launch = 1'b0;
          seq_next.hold   = 1'b1;
        end else if (launch_grant) begin
          seq_next.state       = SEQ_IDLE;
          seq_next.launch      = 1'b0;
          seq_next.resume_done = 1'b1;
        end
      end
    endcase
    if (srst) begin
      seq_next = '{SEQ_IDLE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_reg <= '{SEQ_IDLE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      seq_reg <= seq_next;
    end
  end

  assign quiesce_ask = seq_reg.quiesce;
  assign launch_ask  = seq_reg.launch;
  assign hold        = seq_reg.hold;
  assign halt_done   = seq_reg.halt_done;
  assign resume_done = seq_reg.resume_done;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_grant_freezes;
    @(posedge clk) disable iff (!rst_b || srst)
    (quiesce_ask && quiesce_grant && halt_req) |=> (!quiesce_ask && hold && halt_done);
  endproperty
  a_grant_freezes: assert property (p_grant_freezes) else $error("grant did not freeze");

  property p_halt_cancel;
    @(posedge clk) disable iff (!rst_b || srst)
    (quiesce_ask && !halt_req) |=> (!quiesce_ask && !hold && !halt_done);
  endproperty
  a_halt_cancel: assert property (p_halt_cancel) else $error("halt cancel ignored");

  property p_launch_done;
    @(posedge clk) disable iff (!rst_b || srst)
    (launch_ask && launch_grant && resume_req) |=> (!launch_ask && resume_done && !hold);
  endproperty
  a_launch_done: assert property (p_launch_done) else $error("launch grant not taken");

  property p_resume_cancel;
    @(posedge clk) disable iff (!rst_b || srst)
    (launch_ask && !resume_req) |=> (!launch_ask && !resume_done);
  endproperty
  a_resume_cancel: assert property (p_resume_cancel) else $error("resume cancel ignored");

  property p_done_clear;
    @(posedge clk) disable iff (!rst_b || srst)
    (!halt_req && !resume_req) |=> (!halt_done && !resume_done);
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag stuck");

endmodule

`default_nettype wire

// file: src/violation_log.sv
// Sticky per-bridge access log, write-one-to-clear, and the interrupt it raises
`timescale 1ns/10ps
`default_nettype none

module violation_log #(
  parameter int NUM_BRIDGE = 1,
  parameter bit IRQ_ENABLE = 1'b1
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  srst,
  input  wire logic [NUM_BRIDGE-1:0] violation_in,
  input  wire logic                  clear_wr,
  input  wire logic [NUM_BRIDGE-1:0] clear_mask,
  output logic      [NUM_BRIDGE-1:0] log_bits,
  output logic                       irq
);

  typedef struct packed {
    logic [NUM_BRIDGE-1:0] log;
    logic                  irq;
  } vlog_t;

  vlog_t vlog_reg;
  vlog_t vlog_next;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    vlog_next = vlog_reg;
    if (clear_wr) vlog_next.log = vlog_next.log & ~clear_mask;
    // a new violation beats a clear in the same cycle
    vlog_next.log = vlog_next.log | violation_in;
    // any logged bit raises the interrupt
    vlog_next.irq = IRQ_ENABLE && (|vlog_next.log);
    if (srst) vlog_next = '0;
  end

  // Log register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vlog_reg <= '0;
    end else begin
      vlog_reg <= vlog_next;
    end
  end

  assign log_bits = vlog_reg.log;
  assign irq      = vlog_reg.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_log_sets;
    @(posedge clk) disable iff (!rst_b || srst)
    (|violation_in) |=> ((log_bits & $past(violation_in)) == $past(violation_in));
  endproperty
  a_log_sets: assert property (p_log_sets) else $error("violation not logged");

  property p_w1c;
    @(posedge clk) disable iff (!rst_b || srst)
    (clear_wr && violation_in == '0) |=> (log_bits == ($past(log_bits) & ~$past(clear_mask)));
  endproperty
  a_w1c: assert property (p_w1c) else $error("write-one-clear wrong");

  property p_irq_level;
    @(posedge clk) disable iff (!rst_b || srst)
    (IRQ_ENABLE && (|log_bits)) |-> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt missing");

endmodule

`default_nettype wire

// file: src/region_freeze_controller.sv
// Region freeze controller: register port, control bits, handshake and bridge hold outputs
`timescale 1ns/10ps
`default_nettype none

module region_freeze_controller #(
  parameter int NUM_FREEZE   = 1,
  parameter bit CSR_ENABLE   = 1'b1,
  parameter bit IRQ_ENABLE   = 1'b1,
  parameter bit EXTRA_ENABLE = 1'b0,
  parameter int NUM_EXTRA    = 1
) (
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  input  wire logic                              srst,
  input  wire logic [region_hold_pkg::ADDR_W-1:0] cfg_addr,
  input  wire logic                              cfg_read,
  input  wire logic                              cfg_write,
  input  wire logic [region_hold_pkg::DATA_W-1:0] cfg_wdata,
  output logic      [region_hold_pkg::DATA_W-1:0] cfg_rdata,
  input  wire logic                              conduit_halt_req,
  input  wire logic                              conduit_clear_req,
  input  wire logic                              conduit_resume_req,
  output logic                                   conduit_halt_done,
  output logic                                   conduit_resume_done,
  output logic                                   quiesce_ask,
  input  wire logic                              quiesce_grant,
  output logic                                   launch_ask,
  input  wire logic                              launch_grant,
  output logic                                   persona_reset,
  output logic      [NUM_FREEZE-1:0]             bridge_hold_out,
  input  wire logic [NUM_FREEZE-1:0]             bridge_violation_in,
  output logic      [NUM_EXTRA-1:0]              extra_hold_out,
  output logic                                   irq
);
  import region_hold_pkg::*;

  // ----------------------------------------------------------------
  // Local state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [DATA_W-1:0] rdata;
  } csr_t;

  csr_t csr_reg;
  csr_t csr_next;

  logic                  wr_ctrl;
  logic                  wr_log;
  logic                  rd_hit;
  logic                  hold;
  logic                  halt_done;
  logic                  resume_done;
  logic [NUM_FREEZE-1:0] log_bits;
  logic [NUM_FREEZE-1:0] clear_mask;
  logic [DATA_W-1:0]     log_word;
  logic [DATA_W-1:0]     status_word;
  logic [DATA_W-1:0]     ctrl_word;

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  // word address and separate strobes; with the port left out
  // the strobes are ignored so a floating bus cannot disturb control
  assign wr_ctrl    = CSR_ENABLE && cfg_write && (cfg_addr == ADDR_CTRL);
  assign wr_log     = CSR_ENABLE && cfg_write && (cfg_addr == ADDR_LOG);
  assign rd_hit     = CSR_ENABLE && cfg_read;
  assign clear_mask = cfg_wdata[NUM_FREEZE-1:0];

  // Read words, reserved bits zero
  // full-width data words
  always_comb begin
    // unused bits above each field read zero
    status_word = '0;
    status_word[STAT_HALT_BIT]   = halt_done;
    status_word[STAT_RESUME_BIT] = resume_done;
    ctrl_word = '0;
    ctrl_word[CTRL_W-1:0] = csr_reg.ctrl;
    log_word = '0;
    log_word[NUM_FREEZE-1:0] = log_bits;
  end

  // ----------------------------------------------------------------
  // Control bits and read data
  // ----------------------------------------------------------------
  always_comb begin
    csr_next = csr_reg;
    if (CSR_ENABLE) begin
      // halt bit drops once the freeze is reported done
      if (halt_done) csr_next.ctrl[CTRL_HALT_BIT] = 1'b0;
      // resume bit drops once the launch is reported done
      if (resume_done) csr_next.ctrl[CTRL_RESUME_BIT] = 1'b0;
      // A software write wins over the hardware clear of the same cycle;
      // a zero write here is also how a resume is cancelled
      if (wr_ctrl) csr_next.ctrl = cfg_wdata[CTRL_W-1:0];
      // version answers reads; no write path reaches it
      if (rd_hit) begin
        unique case (cfg_addr)
          ADDR_STATUS:  csr_next.rdata = status_word;
          ADDR_CTRL:    csr_next.rdata = ctrl_word;
          ADDR_LOG:     csr_next.rdata = log_word;
          ADDR_VERSION: csr_next.rdata = LAYOUT_VERSION;
        endcase
      end
    end else begin
      // conduit drives control straight, no self clear
      csr_next.ctrl[CTRL_HALT_BIT]   = conduit_halt_req;
      csr_next.ctrl[CTRL_CLEAR_BIT]  = conduit_clear_req;
      csr_next.ctrl[CTRL_RESUME_BIT] = conduit_resume_req;
      csr_next.rdata = RDATA_RESET;
    end
    if (srst) begin
      csr_next.ctrl  = CTRL_RESET;
      csr_next.rdata = RDATA_RESET;
    end
  end

  // Register state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      csr_reg.ctrl  <= CTRL_RESET;
      csr_reg.rdata <= RDATA_RESET;
    end else begin
      csr_reg <= csr_next;
    end
  end

  // ----------------------------------------------------------------
  // Handshake with the region
  // ----------------------------------------------------------------
  // halt request drives the quiesce handshake
  freeze_sequencer u_seq (
    .clk           (clk),
    .rst_b         (rst_b),
    .srst          (srst),
    .halt_req      (csr_reg.ctrl[CTRL_HALT_BIT]),
    .resume_req    (csr_reg.ctrl[CTRL_RESUME_BIT]),
    .quiesce_grant (quiesce_grant),
    .launch_grant  (launch_grant),
    .quiesce_ask   (quiesce_ask),
    .launch_ask    (launch_ask),
    .hold          (hold),
    .halt_done     (halt_done),
    .resume_done   (resume_done)
  );

  // ----------------------------------------------------------------
  // Violation log and interrupt
  // ----------------------------------------------------------------
  // bridge violation inputs merged into one log word
  violation_log #(
    .NUM_BRIDGE (NUM_FREEZE),
    .IRQ_ENABLE (IRQ_ENABLE)
  ) u_log (
    .clk          (clk),
    .rst_b        (rst_b),
    .srst         (srst),
    .violation_in (bridge_violation_in),
    .clear_wr     (wr_log),
    .clear_mask   (clear_mask),
    .log_bits     (log_bits),
    .irq          (irq)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // persona reset follows the clear bit
  assign persona_reset       = csr_reg.ctrl[CTRL_CLEAR_BIT];
  assign cfg_rdata           = csr_reg.rdata;
  assign conduit_halt_done   = halt_done;
  assign conduit_resume_done = resume_done;

  // one hold output per freeze interface, all the same level
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FREEZE; gi++) begin : g_hold
      assign bridge_hold_out[gi] = hold;
    end
    // extra hold outputs stay low unless enabled
    for (gi = 0; gi < NUM_EXTRA; gi++) begin : g_extra
      assign extra_hold_out[gi] = EXTRA_ENABLE && hold;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_halt_self_clear;
    @(posedge clk) disable iff (!rst_b || srst)
    (CSR_ENABLE && halt_done && !wr_ctrl) |=> !csr_reg.ctrl[CTRL_HALT_BIT];
  endproperty
  a_halt_self_clear: assert property (p_halt_self_clear) else $error("halt bit not cleared");

  property p_resume_self_clear;
    @(posedge clk) disable iff (!rst_b || srst)
    (CSR_ENABLE && resume_done && !wr_ctrl) |=> !csr_reg.ctrl[CTRL_RESUME_BIT];
  endproperty
  a_resume_self_clear: assert property (p_resume_self_clear) else $error("resume bit not cleared");

  property p_version_read;
    @(posedge clk) disable iff (!rst_b || srst)
    (CSR_ENABLE && cfg_read && cfg_addr == ADDR_VERSION) |=> (cfg_rdata == LAYOUT_VERSION);
  endproperty
  a_version_read: assert property (p_version_read) else $error("version read wrong");

  property p_ctrl_reserved;
    @(posedge clk) disable iff (!rst_b || srst)
    (cfg_read && cfg_addr == ADDR_CTRL) |=> (cfg_rdata[DATA_W-1:CTRL_W] == '0);
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved bits nonzero");

  property p_persona_clear;
    @(posedge clk) disable iff (!rst_b || srst)
    (wr_ctrl && cfg_wdata[CTRL_CLEAR_BIT]) |=> persona_reset;
  endproperty
  a_persona_clear: assert property (p_persona_clear) else $error("persona reset not held");

  property p_hold_fanout;
    @(posedge clk) disable iff (!rst_b || srst)
    $rose(hold) |-> (bridge_hold_out == {NUM_FREEZE{1'b1}}) && ($past(quiesce_ask) || $past(launch_ask));
  endproperty
  a_hold_fanout: assert property (p_hold_fanout) else $error("hold without handshake");

  // A cancelled resume refreezes, so hold may also rise out of the launch ask
  property p_reset_release;
    @(posedge clk) disable iff (!rst_b || srst)
    (wr_ctrl && !cfg_wdata[CTRL_CLEAR_BIT]) |=> !persona_reset;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("persona reset not released");

  property p_log_reserved;
    @(posedge clk) disable iff (!rst_b || srst)
    (cfg_read && cfg_addr == ADDR_LOG) |=> ((cfg_rdata >> NUM_FREEZE) == '0);
  endproperty
  a_log_reserved: assert property (p_log_reserved) else $error("log reserved bits nonzero");

  property p_status_read;
    @(posedge clk) disable iff (!rst_b || srst)
    (CSR_ENABLE && cfg_read && cfg_addr == ADDR_STATUS) |=>
      (cfg_rdata[STAT_HALT_BIT] == $past(halt_done)) && (cfg_rdata[STAT_RESUME_BIT] == $past(resume_done));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  // Without the register port the conduit drives control and the bus reads zero
  property p_conduit_follow;
    @(posedge clk) disable iff (!rst_b || srst)
    !CSR_ENABLE |=> (persona_reset == $past(conduit_clear_req)) && (cfg_rdata == RDATA_RESET);
  endproperty
  a_conduit_follow: assert property (p_conduit_follow) else $error("conduit not followed");

  property p_irq_off;
    @(posedge clk) disable iff (!rst_b || srst)
    !IRQ_ENABLE |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");

endmodule

`default_nettype wire

// file: dv/region_model.sv
// Behavioural model of the reconfigurable region: answers quiesce and launch asks
`timescale 1ns/10ps
`default_nettype none

module region_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       quiesce_ask,
  input  wire logic       launch_ask,
  input  wire logic       stall,
  input  wire logic [3:0] delay,
  output logic            quiesce_grant,
  output logic            launch_grant
);
  logic [3:0] q_cnt_reg;
  logic [3:0] l_cnt_reg;

  // ----------------------------------------------------------------
  // Grant logic
  // ----------------------------------------------------------------
  // grant after delay
  // A stalled region never answers, which is the hang that a cancel must escape
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_cnt_reg     <= 4'h0;
      l_cnt_reg     <= 4'h0;
      quiesce_grant <= 1'b0;
      launch_grant  <= 1'b0;
    end else begin
      q_cnt_reg     <= quiesce_ask ? q_cnt_reg + 4'h1 : 4'h0;
      l_cnt_reg     <= launch_ask ? l_cnt_reg + 4'h1 : 4'h0;
      quiesce_grant <= quiesce_ask && !stall && (q_cnt_reg >= delay);
      launch_grant  <= launch_ask && !stall && (l_cnt_reg >= delay);
    end
  end
endmodule

`default_nettype wire

// file: dv/test_region_freeze_controller.sv
// Self-checking bench of the region freeze controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end

module test_region_freeze_controller;
  import region_hold_pkg::*;
  localparam int NB = 4;
  localparam int NX = 2;
  logic              clk, rst_b, srst, cfg_read, cfg_write, stall;
  logic [ADDR_W-1:0] cfg_addr;
  logic [DATA_W-1:0] cfg_wdata, cfg_rdata, rd;
  logic              quiesce_ask, quiesce_grant, launch_ask, launch_grant, persona_reset, irq;
  logic [NB-1:0]     bridge_hold_out, bridge_violation_in, exp_log;
  logic [NX-1:0]     extra_hold_out;
  logic [3:0]        delay;
  logic [31:0]       seed;
  int                num_errors, check_count, i;
  logic [2:0]        cq;
  logic              c_ask, c_irq, c_persona, c_hdone, h_done, r_done;
  logic [DATA_W-1:0] c_rdata;

  region_freeze_controller #(.NUM_FREEZE(NB), .EXTRA_ENABLE(1'b1), .NUM_EXTRA(NX)) u_dut (
    .clk(clk), .rst_b(rst_b), .srst(srst), .cfg_addr(cfg_addr), .cfg_read(cfg_read),
    .cfg_write(cfg_write), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .conduit_halt_req(1'b0), .conduit_clear_req(1'b0), .conduit_resume_req(1'b0),
    .conduit_halt_done(h_done), .conduit_resume_done(r_done), .quiesce_ask(quiesce_ask),
    .quiesce_grant(quiesce_grant), .launch_ask(launch_ask), .launch_grant(launch_grant),
    .persona_reset(persona_reset), .bridge_hold_out(bridge_hold_out),
    .bridge_violation_in(bridge_violation_in), .extra_hold_out(extra_hold_out), .irq(irq));

  region_model u_region (
    .clk(clk), .rst_b(rst_b), .quiesce_ask(quiesce_ask), .launch_ask(launch_ask), .stall(stall),
    .delay(delay), .quiesce_grant(quiesce_grant), .launch_grant(launch_grant));

  // Conduit build without interrupt; its region grants every quiesce ask at once
  region_freeze_controller #(.CSR_ENABLE(1'b0), .IRQ_ENABLE(1'b0)) u_dut2 (
    .clk(clk), .rst_b(rst_b), .srst(srst), .cfg_addr(cfg_addr), .cfg_read(cfg_read),
    .cfg_write(cfg_write), .cfg_wdata(cfg_wdata), .cfg_rdata(c_rdata),
    .conduit_halt_req(cq[0]), .conduit_clear_req(cq[1]), .conduit_resume_req(cq[2]),
    .conduit_halt_done(c_hdone), .conduit_resume_done(), .quiesce_ask(c_ask),
    .quiesce_grant(c_ask), .launch_ask(), .launch_grant(1'b0), .persona_reset(c_persona),
    .bridge_hold_out(), .bridge_violation_in(bridge_violation_in[0]), .extra_hold_out(), .irq(c_irq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Sticky log: clear mask first, a new violation wins over it
  function automatic logic [NB-1:0] log_after(input logic [NB-1:0] cur, input logic [NB-1:0] v,
                                              input logic [NB-1:0] m);
    return (cur & ~m) | v;
  endfunction

  task automatic report_and_stop();
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cfg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    cfg_addr  <= a;
    cfg_wdata <= d;
    cfg_write <= 1'b1;
    @(posedge clk);
    cfg_write <= 1'b0;
  endtask

  // Read data is registered, so it is sampled one edge after the strobe is taken
  task automatic cfg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    cfg_addr <= a;
    cfg_read <= 1'b1;
    @(posedge clk);
    cfg_read <= 1'b0;
    @(posedge clk);
    #1 d = cfg_rdata;
  endtask

  // Bounded wait on an ask or the hold level; running out ends the run
  task automatic wait_for(input int sel, input logic val);
    int   n;
    logic s;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      #1;
      s = (sel == 0) ? quiesce_ask : (sel == 1) ? launch_ask : bridge_hold_out[0];
      if (s === val) break;
    end
    if (n == 200) begin
      num_errors++;
      report_and_stop();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0; srst = 1'b0; cfg_read = 1'b0; cfg_write = 1'b0; cfg_addr = '0; cfg_wdata = '0;
    bridge_violation_in = '0; stall = 1'b0; delay = 4'h0; seed = 32'd86338; cq = '0;
    num_errors = 0; check_count = 0; exp_log = '0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    cq <= 3'h3;
    cfg_rd(ADDR_CTRL, rd);
    `CHK(rd, 32'h0000_0000)
    cfg_rd(ADDR_STATUS, rd);
    `CHK(rd, 32'h0000_0000)
    `CHK(bridge_hold_out, {NB{1'b0}})
    cfg_rd(ADDR_VERSION, rd);
    `CHK(rd, LAYOUT_VERSION)
    cfg_wr(ADDR_VERSION, 32'hFFFF_FFFF);
    cfg_rd(ADDR_VERSION, rd);
    `CHK(rd, LAYOUT_VERSION)
    // Persona clear with every reserved bit written high
    cfg_wr(ADDR_CTRL, 32'hFFFF_FFFA);
    cfg_rd(ADDR_CTRL, rd);
    `CHK(rd, 32'h0000_0002)
    `CHK(persona_reset, 1'b1)
    cfg_wr(ADDR_CTRL, 32'h0);
    @(posedge clk);
    #1 `CHK(persona_reset, 1'b0)
    // Freeze and release rounds; halt and resume are never set together
    for (i = 0; i < 6; i++) begin
      seed = xorshift(seed);
      delay <= seed[3:0] & 4'h7;
      stall <= (i == 2);
      cfg_wr(ADDR_CTRL, 32'h1);
      wait_for(0, 1'b1);
      if (i == 2) begin
        cfg_wr(ADDR_CTRL, 32'h0);
        wait_for(0, 1'b0);
        @(posedge clk);
        #1 `CHK(bridge_hold_out, {NB{1'b0}})
        `CHK(h_done, 1'b0)
      end else begin
        wait_for(2, 1'b1);
        `CHK(quiesce_ask, 1'b0)
        `CHK(h_done, 1'b1)
        `CHK(bridge_hold_out, {NB{1'b1}})
        `CHK(extra_hold_out, {NX{1'b1}})
        cfg_rd(ADDR_CTRL, rd);
        `CHK(rd, 32'h0)
        `CHK(h_done, 1'b0)
        stall <= (i == 4);
        cfg_wr(ADDR_CTRL, 32'h4);
        wait_for(1, 1'b1);
        `CHK(bridge_hold_out, {NB{1'b0}})
        if (i == 4) begin
          cfg_wr(ADDR_CTRL, 32'h0);
          wait_for(1, 1'b0);
          @(posedge clk);
          #1 `CHK(bridge_hold_out, {NB{1'b1}})
          `CHK(r_done, 1'b0)
          stall <= 1'b0;
          cfg_wr(ADDR_CTRL, 32'h4);
        end
        wait_for(1, 1'b0);
        `CHK(extra_hold_out, {NX{1'b0}})
        `CHK(r_done, 1'b1)
        cfg_rd(ADDR_CTRL, rd);
        `CHK(rd, 32'h0)
        `CHK(r_done, 1'b0)
      end
    end
    // Random violations and write-one-to-clear masks
    for (i = 0; i < 40; i++) begin
      seed = xorshift(seed);
      if (seed[8]) begin
        @(posedge clk);
        bridge_violation_in <= seed[NB-1:0];
        @(posedge clk);
        bridge_violation_in <= '0;
        exp_log = log_after(exp_log, seed[NB-1:0], '0);
      end else begin
        cfg_wr(ADDR_LOG, seed >> 4);
        exp_log = log_after(exp_log, '0, seed[NB+3:4]);
      end
      cfg_rd(ADDR_LOG, rd);
      `CHK(rd, {{(DATA_W-NB){1'b0}}, exp_log})
      `CHK(irq, |exp_log)
    end
    // A violation in the cycle of a clear survives it
    @(posedge clk);
    cfg_addr <= ADDR_LOG; cfg_wdata <= 32'hFFFF_FFFF; cfg_write <= 1'b1; bridge_violation_in <= 4'h1;
    @(posedge clk);
    cfg_write <= 1'b0; bridge_violation_in <= '0;
    cfg_rd(ADDR_LOG, rd);
    `CHK(rd, 32'h0000_0001)
    // Conduit build: control follows the conduit, bus ignored, no interrupt
    `CHK(c_hdone, 1'b1)
    `CHK(c_persona, 1'b1)
    `CHK(c_rdata, 32'h0)
    `CHK(c_irq, 1'b0)
    // Synchronous reset in mid-run
    cfg_wr(ADDR_CTRL, 32'h2);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    cfg_rd(ADDR_CTRL, rd);
    `CHK(rd, 32'h0)
    `CHK(persona_reset, 1'b0)
    cfg_rd(ADDR_LOG, rd);
    `CHK(rd, 32'h0)
    `CHK(irq, 1'b0)
    report_and_stop();
  end
endmodule

`default_nettype wire
